// >>> pkg/lacc_pkg.sv
// lacc_pkg: register map, field layout and enumerations for the commutation controller.
// assumes a 32-bit apb slave whose printed offsets are word indices.
package lacc_pkg;
   localparam int LACC_AW = 10;
   // register indices (byte address is four times the index)
   localparam logic [7:0] LACC_IDX_GENCONF = 8'h00;
   localparam logic [7:0] LACC_IDX_REFCONF = 8'h01;
   localparam logic [7:0] LACC_IDX_SWVEL = 8'h1D;
   localparam logic [7:0] LACC_IDX_THRVEL = 8'h60;
   localparam logic [7:0] LACC_IDX_TIMING = 8'h61;
   localparam logic [7:0] LACC_IDX_LSTMR = 8'h62;
   localparam logic [7:0] LACC_IDX_COVLO = 8'h6C;
   localparam logic [7:0] LACC_IDX_COVHI = 8'h6D;
   localparam logic [7:0] LACC_IDX_STATUS = 8'h70;
   localparam logic [7:0] LACC_IDX_MASK = 8'h71;
   // general configuration fields
   localparam int LACC_MODE_LSB = 21;
   localparam logic [1:0] LACC_MODE_ON = 2'h1;
   localparam int LACC_FMT_LSB = 0;
   localparam logic [3:0] LACC_FMT_PULSE_A = 4'hB;
   localparam logic [3:0] LACC_FMT_PULSE_B = 4'hA;
   localparam logic [3:0] LACC_FMT_HS_A = 4'hD;
   localparam logic [3:0] LACC_FMT_HS_B = 4'hC;
   // reference configuration: automatic cover bit
   localparam int LACC_AUTOCOV_BIT = 0;
   // timing register fields
   localparam int LACC_UPPER_LSB = 0;
   localparam int LACC_STALL_LSB = 8;
   localparam int LACC_BLANK_LSB = 16;
   localparam int LACC_STALL_SHIFT = 4;
   // status bits
   localparam int LACC_ST_STALL = 0;
   localparam int LACC_ST_ACTIVE = 1;
   localparam int LACC_ST_FORCED = 2;
   localparam logic [31:0] LACC_RST_WORD = 32'h0000_0000;
   typedef enum logic [1:0] {LACC_BLANK, LACC_WAIT, LACC_MEAS} lacc_pulse_type;
endpackage

// >>> core/lacc_ctrl.sv
// lacc_ctrl: load-adaptive fullstep commutation controller with apb registers.
// assumes ramp velocity and step release come from the ramp generator on pclk,
// and that the driver pin and cover datagram link are synchronous to pclk.
`timescale 1ns/100ps
module lacc_ctrl
   import lacc_pkg::*;
#(
   parameter int VEL_W = 32
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [LACC_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic signed [VEL_W-1:0] ramp_velocity,
   input wire logic step_release,
   input wire logic driver_stall_in,
   input wire logic multipurpose_input_one,
   output logic multipurpose_output_two,
   output logic step_pause,
   output logic step_force,
   output logic stall_status,
   output logic [31:0] cover_data,
   output logic cover_send,
   input wire logic cover_ready,
   output logic irq
);
   logic [31:0] gen_q, gen_d, ref_q, ref_d, swv_q, swv_d, tim_q, tim_d;
   logic [31:0] lst_q, lst_d, cvl_q, cvl_d, cvh_q, cvh_d;
   logic [23:0] thr_q, thr_d;
   logic [2:0] sts_q, sts_d, msk_q, msk_d;
   logic [31:0] rd_q, rd_d;
   logic [31:0] lsc_q, lsc_d;
   logic [15:0] cnt_q, cnt_d;
   logic [12:0] on_q, on_d;
   lacc_pulse_type ps_q, ps_d;
   logic pause_q, pause_d, check_q, check_d, force_q, force_d;
   logic in_q, above_q, above_d, sent_q, sent_d, cov_q, cov_d;
   logic [31:0] cdat_q, cdat_d;

   // byte-lane merge shared by every writable word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   logic [7:0] idx;
   logic wr, rd, hit;
   logic [VEL_W-1:0] absv;
   logic en, act, pulse_mode, hs_mode, thr_ge, sw_above;
   logic [3:0] fmt;
   logic [12:0] stall_lim;
   logic rise, fall;
   assign idx = paddr[9:2];
   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign pready = 1'b1; // zero wait states
   assign absv = ramp_velocity[VEL_W-1] ? VEL_W'(-ramp_velocity) : ramp_velocity;
   assign fmt = gen_q[LACC_FMT_LSB +: 4];
   assign en = gen_q[LACC_MODE_LSB +: 2] == LACC_MODE_ON;
   assign act = en & (absv > VEL_W'(thr_q));
   assign thr_ge = absv >= VEL_W'(thr_q);
   assign pulse_mode = (fmt == LACC_FMT_PULSE_A) | (fmt == LACC_FMT_PULSE_B);
   assign hs_mode = (fmt == LACC_FMT_HS_A) | (fmt == LACC_FMT_HS_B);
   assign sw_above = absv >= VEL_W'(swv_q);
   assign stall_lim = {1'b0, tim_q[LACC_STALL_LSB +: 8], 4'h0}; // times 16
   assign rise = multipurpose_input_one & ~in_q;
   assign fall = ~multipurpose_input_one & in_q;

   always_comb begin
      hit = 1'b1;
      case (idx)
         LACC_IDX_GENCONF, LACC_IDX_REFCONF, LACC_IDX_SWVEL, LACC_IDX_THRVEL,
         LACC_IDX_TIMING, LACC_IDX_LSTMR, LACC_IDX_COVLO, LACC_IDX_COVHI,
         LACC_IDX_STATUS, LACC_IDX_MASK: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~hit;

   // register file next state; write-only words read back as zero
   always_comb begin
      gen_d = gen_q;
      ref_d = ref_q;
      swv_d = swv_q;
      thr_d = thr_q;
      tim_d = tim_q;
      lst_d = lst_q;
      cvl_d = cvl_q;
      cvh_d = cvh_q;
      msk_d = msk_q;
      rd_d = LACC_RST_WORD;
      if (wr) begin
         case (idx)
            LACC_IDX_GENCONF: gen_d = merge(gen_q, pwdata, pstrb);
            LACC_IDX_REFCONF: ref_d = merge(ref_q, pwdata, pstrb);
            LACC_IDX_SWVEL: swv_d = merge(swv_q, pwdata, pstrb);
            LACC_IDX_THRVEL: thr_d = 24'(merge({8'h00, thr_q}, pwdata, pstrb));
            LACC_IDX_TIMING: tim_d = merge(tim_q, pwdata, pstrb);
            LACC_IDX_LSTMR: lst_d = merge(lst_q, pwdata, pstrb);
            LACC_IDX_COVLO: cvl_d = merge(cvl_q, pwdata, pstrb);
            LACC_IDX_COVHI: cvh_d = merge(cvh_q, pwdata, pstrb);
            LACC_IDX_MASK: msk_d = 3'(merge({29'h0, msk_q}, pwdata, pstrb));
            default: ;
         endcase
      end
      if (psel & ~penable & ~pwrite) begin
         case (idx)
            LACC_IDX_GENCONF: rd_d = gen_q;
            LACC_IDX_REFCONF: rd_d = ref_q;
            LACC_IDX_SWVEL: rd_d = swv_q;
            LACC_IDX_COVLO: rd_d = cvl_q;
            LACC_IDX_COVHI: rd_d = cvh_q;
            LACC_IDX_STATUS: rd_d = {29'h0, sts_q};
            LACC_IDX_MASK: rd_d = {29'h0, msk_q};
            default: rd_d = LACC_RST_WORD;
         endcase
      end
   end
   assign prdata = rd_q;

   // pulse supervision: blank after release, then time pulses on the input pin
   always_comb begin
      ps_d = ps_q;
      cnt_d = cnt_q;
      on_d = on_q;
      check_d = check_q;
      pause_d = pause_q;
      if (step_release | step_force) begin
         ps_d = LACC_BLANK;
         cnt_d = 16'h0000;
         check_d = 1'b1;
      end else begin
         case (ps_q)
            LACC_BLANK: begin
               if (cnt_q >= tim_q[LACC_BLANK_LSB +: 16]) begin
                  ps_d = LACC_WAIT;
               end else begin
                  cnt_d = cnt_q + 16'h0001;
               end
            end
            LACC_WAIT: begin
               if (rise) begin
                  ps_d = LACC_MEAS;
                  on_d = 13'h0000;
               end
            end
            LACC_MEAS: begin
               if (fall) begin
                  ps_d = LACC_WAIT;
                  check_d = 1'b0;
               end else if (on_q != 13'h1FFF) begin
                  on_d = on_q + 13'h0001;
               end
            end
            default: ps_d = LACC_BLANK;
         endcase
      end
      // overload pause: a pulse reaching the upper limit halts steps until one ends short
      if (~(act & pulse_mode)) begin
         pause_d = 1'b0;
      end else if (ps_q == LACC_MEAS && on_q >= {5'h00, tim_q[LACC_UPPER_LSB +: 8]}) begin
         pause_d = 1'b1;
      end else if (ps_q == LACC_MEAS && fall) begin
         pause_d = 1'b0;
      end
   end

   // low speed timer forces a step while the pause is held
   always_comb begin
      lsc_d = lsc_q;
      force_d = 1'b0;
      if (~en | ~pause_q | step_release) begin
         lsc_d = 32'h0000_0000;
      end else if (lsc_q + 32'h0000_0001 >= lst_q) begin // a zero word forces every cycle
         lsc_d = 32'h0000_0000;
         force_d = 1'b1;
      end else begin
         lsc_d = lsc_q + 32'h0000_0001;
      end
   end

   // sticky status: a read clears only the bits it returned, so an event landing
   // in the setup cycle is not lost; a set in the access cycle wins as well
   logic ev_stall;
   assign ev_stall = pulse_mode & act & check_q & (ps_q == LACC_MEAS) & fall
                     & (on_q < stall_lim);
   always_comb begin
      sts_d = sts_q;
      if (rd && idx == LACC_IDX_STATUS) begin
         sts_d = sts_q & ~rd_q[2:0];
      end
      if (ev_stall) begin
         sts_d[LACC_ST_STALL] = 1'b1;
      end
      if (act & ~above_q) begin
         sts_d[LACC_ST_ACTIVE] = 1'b1;
      end
      if (force_q) begin
         sts_d[LACC_ST_FORCED] = 1'b1;
      end
   end

   // cover datagram choice on each crossing of the switch velocity
   always_comb begin
      above_d = act;
      sent_d = sent_q;
      cov_d = cov_q;
      cdat_d = cdat_q;
      if (cov_q & cover_ready) begin
         cov_d = 1'b0;
      end
      if (ref_q[LACC_AUTOCOV_BIT] & ~cov_q & (sw_above != sent_q)) begin
         cov_d = 1'b1;
         sent_d = sw_above;
         cdat_d = sw_above ? cvh_q : cvl_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gen_q <= LACC_RST_WORD;
         ref_q <= LACC_RST_WORD;
         swv_q <= LACC_RST_WORD;
         thr_q <= 24'h000000;
         tim_q <= LACC_RST_WORD;
         lst_q <= LACC_RST_WORD;
         cvl_q <= LACC_RST_WORD;
         cvh_q <= LACC_RST_WORD;
         msk_q <= 3'h0;
         sts_q <= 3'h0;
         rd_q <= LACC_RST_WORD;
         ps_q <= LACC_BLANK;
         cnt_q <= 16'h0000;
         on_q <= 13'h0000;
         check_q <= 1'b0;
         pause_q <= 1'b0;
         lsc_q <= 32'h0000_0000;
         force_q <= 1'b0;
         in_q <= 1'b0;
         above_q <= 1'b0;
         sent_q <= 1'b0;
         cov_q <= 1'b0;
         cdat_q <= LACC_RST_WORD;
      end else begin
         gen_q <= gen_d;
         ref_q <= ref_d;
         swv_q <= swv_d;
         thr_q <= thr_d;
         tim_q <= tim_d;
         lst_q <= lst_d;
         cvl_q <= cvl_d;
         cvh_q <= cvh_d;
         msk_q <= msk_d;
         sts_q <= sts_d;
         rd_q <= rd_d;
         ps_q <= ps_d;
         cnt_q <= cnt_d;
         on_q <= on_d;
         check_q <= check_d;
         pause_q <= pause_d;
         lsc_q <= lsc_d;
         force_q <= force_d;
         in_q <= multipurpose_input_one;
         above_q <= above_d;
         sent_q <= sent_d;
         cov_q <= cov_d;
         cdat_q <= cdat_d;
      end
   end

   // handshake drivers commutate themselves, so no pause is applied there
   assign multipurpose_output_two = hs_mode & en & thr_ge;
   assign step_pause = pause_q & pulse_mode;
   assign step_force = force_q;
   assign stall_status = pulse_mode ? sts_q[LACC_ST_STALL] : driver_stall_in;
   assign cover_data = cdat_q;
   assign cover_send = cov_q;
   assign irq = |(sts_q & msk_q);

   // a stall seen on a falling pulse edge must show in the status stall bit at the next edge
   property p_stall_sticky;
      @(posedge pclk) disable iff (!presetn) ev_stall |=> sts_q[LACC_ST_STALL];
   endproperty
   a_stall_sticky: assert property (p_stall_sticky) else $error("stall lost");
   property p_out_two;
      @(posedge pclk) disable iff (!presetn)
         (hs_mode & en & thr_ge) |-> multipurpose_output_two;
   endproperty
   a_out_two: assert property (p_out_two) else $error("output two low");
   property p_nopause_hs;
      @(posedge pclk) disable iff (!presetn) hs_mode |-> !step_pause;
   endproperty
   a_nopause_hs: assert property (p_nopause_hs) else $error("pause in handshake");
   property p_off_mode;
      @(posedge pclk) disable iff (!presetn) !en |=> !pause_q;
   endproperty
   a_off_mode: assert property (p_off_mode) else $error("pause while disabled");
   property p_force;
      @(posedge pclk) disable iff (!presetn) force_q |-> $past(pause_q);
   endproperty
   a_force: assert property (p_force) else $error("forced step without pause");
   property p_pause_act;
      @(posedge pclk) disable iff (!presetn) pause_q |-> $past(act);
   endproperty
   a_pause_act: assert property (p_pause_act) else $error("pause while inactive");
   property p_stall_sel;
      @(posedge pclk) disable iff (!presetn) !pulse_mode |-> stall_status == driver_stall_in;
   endproperty
   a_stall_sel: assert property (p_stall_sel) else $error("stall source wrong");
   property p_blank;
      @(posedge pclk) disable iff (!presetn) (step_release & !step_force) |=> ps_q == LACC_BLANK;
   endproperty
   a_blank: assert property (p_blank) else $error("blank not entered");
   property p_cover;
      @(posedge pclk) disable iff (!presetn) $rose(cov_q) |-> cdat_q == (sent_q ? cvh_q : cvl_q);
   endproperty
   a_cover: assert property (p_cover) else $error("wrong cover word");
   // a datagram taken by the driver must drop the send request on the next edge
   sequence s_cover_taken;
      cov_q & cover_ready;
   endsequence
   property p_cover_done;
      @(posedge pclk) disable iff (!presetn) s_cover_taken |=> !cov_q;
   endproperty
   a_cover_done: assert property (p_cover_done) else $error("send not dropped");
endmodule

// >>> test/lacc_driver_model.sv
// lacc_driver_model: behavioural stepper driver at the far side of the controller.
// assumes pclk-synchronous pins; the bench asks for each commutation pulse and its length.
`timescale 1ns/100ps
module lacc_driver_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pulse_go,
   input wire logic [7:0] pulse_len,
   input wire logic report_stall,
   input wire logic [3:0] ready_delay,
   input wire logic cover_send,
   output logic multipurpose_input_one,
   output logic driver_stall_in,
   output logic cover_ready
);
   logic [7:0] on_q;
   logic [3:0] wait_q;
   // pulse line is high while the on-time counter runs, low otherwise
   assign multipurpose_input_one = on_q != 8'h00;
   // datagram accept comes after a chosen delay; the bench only ever uses a ready_delay of 3
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_q <= 8'h00;
         wait_q <= 4'h0;
         cover_ready <= 1'b0;
         driver_stall_in <= 1'b0;
      end else begin
         on_q <= pulse_go ? pulse_len : (on_q != 8'h00 ? on_q - 8'h01 : 8'h00);
         driver_stall_in <= report_stall;
         cover_ready <= cover_send && !cover_ready && wait_q == ready_delay;
         wait_q <= (cover_send && !cover_ready && wait_q != ready_delay) ? wait_q + 4'h1 : 4'h0;
      end
   end
endmodule

// >>> test/testbench.sv
// testbench: apb-driven checks of the commutation controller against a driver model.
// assumes a zero-wait apb slave and the register layout of lacc_pkg.
`timescale 1ns/100ps
module testbench;
   import lacc_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, cover_data, got;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, err, pin_one, pin_two, step_pause, step_force, stall_status, irq;
   logic step_release = 1'b0, pulse_go = 1'b0, report_stall = 1'b1;
   logic driver_stall_in, cover_send, cover_ready;
   logic [7:0] pulse_len = 8'h00;
   logic signed [31:0] vel = 32'sh0;
   logic [3:0] hs [2] = '{LACC_FMT_HS_A, LACC_FMT_HS_B};
   int mismatches = 0, checked = 0, cycles = 0, n;
   always #25 pclk = ~pclk;
   lacc_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ramp_velocity(vel), .step_release(step_release),
      .driver_stall_in(driver_stall_in), .multipurpose_input_one(pin_one),
      .multipurpose_output_two(pin_two), .step_pause(step_pause), .step_force(step_force),
      .stall_status(stall_status), .cover_data(cover_data), .cover_send(cover_send),
      .cover_ready(cover_ready), .irq(irq));
   lacc_driver_model drv_u (.pclk(pclk), .presetn(presetn), .pulse_go(pulse_go),
      .pulse_len(pulse_len), .report_stall(report_stall), .ready_delay(4'h3),
      .cover_send(cover_send), .multipurpose_input_one(pin_one),
      .driver_stall_in(driver_stall_in), .cover_ready(cover_ready));
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // a hang ends the run well after the expected few hundred cycles
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         final_report();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one apb transfer: setup, then access held until pready is sampled high
   task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // no cycle count is assumed; only the bench timeout ends this wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wait_cyc(input int c);
      repeat (c) @(posedge pclk);
   endtask
   task automatic pulse(input logic [7:0] len);
      pulse_go <= 1'b1;
      pulse_len <= len;
      @(posedge pclk);
      pulse_go <= 1'b0;
      wait_cyc(int'(len) + 3);
   endtask
   task automatic release_step;
      step_release <= 1'b1;
      @(posedge pclk);
      step_release <= 1'b0;
   endtask
   // first datagram accepted by the driver within the window
   task automatic catch_cover(output logic [31:0] d);
      d = 32'hFFFF_FFFF;
      repeat (60) begin
         @(posedge pclk);
         if (cover_send === 1'b1 && cover_ready === 1'b1 && d === 32'hFFFF_FFFF) d = cover_data;
      end
   endtask
   initial begin
      wait_cyc(16);
      presetn <= 1'b1;
      @(posedge pclk);
      // register map: reset word, read-back, write-only and unmapped places
      xfer(LACC_IDX_GENCONF, 1'b0, 32'h0);
      chk("general configuration", 32'h0000_0000, rd);
      xfer(LACC_IDX_COVLO, 1'b1, 32'hA5A5_0001);
      xfer(LACC_IDX_COVLO, 1'b0, 32'h0);
      chk("cover low", 32'hA5A5_0001, rd);
      xfer(LACC_IDX_THRVEL, 1'b1, 32'h0000_03E8);
      xfer(LACC_IDX_THRVEL, 1'b0, 32'h0);
      chk("threshold read", 32'h0000_0000, rd);
      xfer(8'h05, 1'b0, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      // handshake variant: output two follows |v| >= threshold
      foreach (hs[i]) begin
         xfer(LACC_IDX_GENCONF, 1'b1, {9'h000, LACC_MODE_ON, 17'h00000, hs[i]});
         vel <= 32'sd1000;
         wait_cyc(2);
         chk("output two at threshold", 32'h1, {31'h0, pin_two});
         vel <= -32'sd1200;
         wait_cyc(2);
         chk("output two negative", 32'h1, {31'h0, pin_two});
         chk("no pause in handshake", 32'h0, {31'h0, step_pause});
         vel <= 32'sd999;
         wait_cyc(2);
         chk("output two below", 32'h0, {31'h0, pin_two});
         chk("driver stall passed", 32'h1, {31'h0, stall_status});
      end
      xfer(LACC_IDX_GENCONF, 1'b1, {9'h000, 2'h2, 17'h00000, LACC_FMT_HS_A});
      vel <= 32'sd2000;
      wait_cyc(2);
      chk("output two mode off", 32'h0, {31'h0, pin_two});
      // pulse variant: blank 16, stall 1*16, upper 20 cycles
      xfer(LACC_IDX_TIMING, 1'b1, 32'h0010_0114);
      xfer(LACC_IDX_LSTMR, 1'b1, 32'h0000_1000);
      xfer(LACC_IDX_MASK, 1'b1, 32'h0000_0001);
      // the second pulse format code must pick the own stall bit too
      xfer(LACC_IDX_GENCONF, 1'b1, {9'h000, LACC_MODE_ON, 17'h00000, LACC_FMT_PULSE_B});
      wait_cyc(2);
      chk("own stall second format", 32'h0, {31'h0, stall_status});
      xfer(LACC_IDX_GENCONF, 1'b1, {9'h000, LACC_MODE_ON, 17'h00000, LACC_FMT_PULSE_A});
      wait_cyc(2);
      chk("output two pulse variant", 32'h0, {31'h0, pin_two});
      chk("own stall replaces driver", 32'h0, {31'h0, stall_status});
      release_step();
      pulse(8'h03);
      wait_cyc(16);
      pulse(8'h19);
      chk("pause after long pulse", 32'h1, {31'h0, step_pause});
      chk("blanked short pulse", 32'h0, {31'h0, stall_status});
      pulse(8'h0A);
      chk("pause lifted", 32'h0, {31'h0, step_pause});
      chk("later short pulse", 32'h0, {31'h0, stall_status});
      release_step();
      wait_cyc(18);
      pulse(8'h05);
      wait_cyc(20);
      chk("stall sticky", 32'h1, {31'h0, stall_status});
      chk("irq on stall", 32'h1, {31'h0, irq});
      xfer(LACC_IDX_STATUS, 1'b0, 32'h0);
      chk("status stall bit", 32'h1, rd & 32'h1);
      chk("irq after read", 32'h0, {31'h0, irq});
      // low speed timer forces a step every 10 cycles while paused
      xfer(LACC_IDX_LSTMR, 1'b1, 32'h0000_000A);
      release_step();
      wait_cyc(18);
      pulse(8'h19);
      n = 0;
      repeat (100) begin
         @(posedge pclk);
         if (step_force === 1'b1) n++;
      end
      chk("forced steps", 32'h0000_000A, n);
      vel <= 32'sd0;
      wait_cyc(3);
      chk("pause gone when inactive", 32'h0, {31'h0, step_pause});
      // cover datagrams around the switch speed, set just under the threshold
      xfer(LACC_IDX_COVHI, 1'b1, 32'h5A5A_0002);
      xfer(LACC_IDX_SWVEL, 1'b1, 32'h0000_03E0);
      xfer(LACC_IDX_REFCONF, 1'b1, 32'h0000_0001);
      wait_cyc(30);
      vel <= 32'sd2000;
      catch_cover(got);
      chk("cover high sent", 32'h5A5A_0002, got);
      vel <= 32'sd0;
      catch_cover(got);
      chk("cover low sent", 32'hA5A5_0001, got);
      final_report();
   end
endmodule
